// ===== hw/rpc_pkg.sv
/*
  Constants shared by the register page control block: offsets, field positions,
  reset values, page windows and the state type of the access sequencer.
  Assumes a protocol engine on the same clock that frames 2-wire and 4-wire accesses.
*/
// Function
// [R01] With auto return set, page field goes to 000 when the access ends.
// [R02] Bit 6 picks 2-wire multiple write: 0 page write, 1 repeated write.
// [R03] Multiple write selection is ignored for 4-wire transfers.
// [R04] 2-wire page decode ignores bit 0: 00x, 01x, 10x windows.
// [R05] 4-wire page decode: 000, 001, 010, 100 select 128-register windows.
// [R06] Without auto return, page stays until the host writes a new one.
package rpc_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] RPC_PAGE_CTL_SHORT = 8'h00;
  localparam logic [9:0] RPC_VARIANT_OFF = 10'h202;
  localparam logic [9:0] RPC_CUSTOMER_OFF = 10'h203;
  localparam logic [9:0] RPC_CONFIG_OFF = 10'h204;

  // ==========================================================================
  // page control fields and reset value
  localparam int RPC_AUTO_RET_BIT = 7;
  localparam int RPC_WMODE_BIT = 6;
  localparam int RPC_PAGE_MSB = 2;
  localparam logic [7:0] RPC_PAGE_CTL_RST = 8'h00;
  localparam logic [7:0] RPC_PAGE_CTL_MASK = 8'hC7;
  localparam logic [2:0] RPC_PAGE_ZERO = 3'h0;

  // ==========================================================================
  // page windows
  localparam logic [9:0] RPC_BASE_0 = 10'h000;
  localparam logic [9:0] RPC_BASE_80 = 10'h080;
  localparam logic [9:0] RPC_BASE_100 = 10'h100;
  localparam logic [9:0] RPC_BASE_200 = 10'h200;
  localparam logic [2:0] RPC_SPI_PG0 = 3'h0;
  localparam logic [2:0] RPC_SPI_PG1 = 3'h1;
  localparam logic [2:0] RPC_SPI_PG2 = 3'h2;
  localparam logic [2:0] RPC_SPI_PG4 = 3'h4;
  localparam logic [1:0] RPC_TW_PG0 = 2'h0;
  localparam logic [1:0] RPC_TW_PG1 = 2'h1;
  localparam logic [1:0] RPC_TW_PG2 = 2'h2;

  // ==========================================================================
  // sequencer states, gray along idle -> data -> address
  typedef enum logic [1:0] {
    RPC_IDLE = 2'h0,
    RPC_DATA = 2'h1,
    RPC_ADDR = 2'h3
  } rpc_state_t;

endpackage

// ===== hw/rpc_map_if.sv
/*
  Carrier between the page control core and its address mapper.
  Assumes both ends sit in the same clock domain; the mapping is combinational.
*/
`timescale 1ns/10ps
interface rpc_map_if;
  logic [2:0] page;
  logic isSpi;
  logic [7:0] shortAddr;
  logic [9:0] fullAddr;
  logic inRange;

  modport ctl (
    output page,
    output isSpi,
    output shortAddr,
    input fullAddr,
    input inRange
  );

  modport map (
    input page,
    input isSpi,
    input shortAddr,
    output fullAddr,
    output inRange
  );
endinterface

// ===== hw/rpc_page_map.sv
/*
  Address mapper: turns a short register address and the page field into a
  full register address. Assumes the caller says which interface carries the access.
*/
`timescale 1ns/10ps
module rpc_page_map
  import rpc_pkg::*;
(
  rpc_map_if.map mp
);

  // ==========================================================================
  // 2-wire windows, lowest page bit ignored
  logic [1:0] twPage;
  logic [9:0] twBase;
  logic twOk;
  assign twPage = mp.page[2:1]; // R04
  assign twBase = (twPage == RPC_TW_PG0) ? RPC_BASE_0 : (twPage == RPC_TW_PG1) ? RPC_BASE_100 : RPC_BASE_200;
  // the first window spans a whole byte, the others only 128 registers
  assign twOk = (twPage == RPC_TW_PG0) || (((twPage == RPC_TW_PG1) || (twPage == RPC_TW_PG2)) && !mp.shortAddr[7]); // R04

  // ==========================================================================
  // 4-wire windows, all 128 registers wide
  logic [9:0] spiBase;
  logic spiPgOk;
  logic spiOk;
  assign spiPgOk = (mp.page == RPC_SPI_PG0) || (mp.page == RPC_SPI_PG1) || (mp.page == RPC_SPI_PG2) ||
                   (mp.page == RPC_SPI_PG4); // R05
  assign spiBase = (mp.page == RPC_SPI_PG1) ? RPC_BASE_80 : (mp.page == RPC_SPI_PG2) ? RPC_BASE_100 :
                   (mp.page == RPC_SPI_PG4) ? RPC_BASE_200 : RPC_BASE_0; // R05
  assign spiOk = spiPgOk && !mp.shortAddr[7]; // R05

  // ==========================================================================
  // selection by interface
  logic [9:0] offset;
  assign offset = {2'h0, mp.shortAddr};
  assign mp.fullAddr = (mp.isSpi ? spiBase : twBase) + offset;
  assign mp.inRange = mp.isSpi ? spiOk : twOk;

endmodule

// ===== hw/rpc_page_control.sv
/*
  Register page control core: holds the page control register, tracks the
  current register address of an access, handles 2-wire multiple writes and
  serves the identity registers. Assumes a protocol engine on ref_clk that
  frames accesses with start, byte and end pulses; other registers live outside.
*/
`timescale 1ns/10ps
module rpc_page_control
  import rpc_pkg::*;
#(
  parameter logic [3:0] MASK_REV_VAL = 4'h1,   // arbitrary value
  parameter logic [3:0] VARIANT_REV_VAL = 4'h2, // arbitrary value
  parameter logic [7:0] CUSTOMER_VAL = 8'h5A,   // arbitrary value
  parameter logic [7:0] CONFIGURATION_REVISION_FIELD_VAL = 8'h01  // arbitrary value
)(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic accStart,
  input wire logic [7:0] accAddr,
  input wire logic accIsSpi,
  input wire logic accWrite,
  input wire logic accByteValid,
  input wire logic [7:0] accByte,
  input wire logic accEnd,
  input wire logic [7:0] extRdData,
  output logic regWrite,
  output logic regRead,
  output logic [9:0] regAddr,
  output logic [7:0] regWdata,
  output logic [7:0] rdData,
  output logic addrValid,
  output logic [2:0] pageSel,
  output logic autoReturnPage,
  output logic repeatedWrite
);

  // ==========================================================================
  // state
  rpc_state_t state_reg;
  rpc_state_t state_next;
  logic [7:0] pageCtl_reg;
  logic [7:0] pageCtl_next;
  logic [7:0] curAddr_reg;
  logic [7:0] curAddr_next;
  logic spi_reg;
  logic spi_next;
  logic regWrite_reg;
  logic regRead_reg;
  logic [9:0] regAddr_reg;
  logic [7:0] regWdata_reg;
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;

  // ==========================================================================
  // address mapping
  rpc_map_if mapIf ();
  rpc_page_map u_map (
    .mp(mapIf)
  );
  assign mapIf.page = pageCtl_reg[RPC_PAGE_MSB:0];
  assign mapIf.isSpi = spi_reg;
  assign mapIf.shortAddr = curAddr_reg;

  // ==========================================================================
  // decode of the current address
  logic hitPageCtl;
  logic hitVariant;
  logic hitCustomer;
  logic hitConfig;
  logic hitLocal;
  logic [7:0] idVariant;
  // page control answers at short address zero in every window, so the host
  // can always leave a page without first knowing which one is selected
  assign hitPageCtl = (curAddr_reg == RPC_PAGE_CTL_SHORT);
  assign hitVariant = mapIf.inRange && (mapIf.fullAddr == RPC_VARIANT_OFF);
  assign hitCustomer = mapIf.inRange && (mapIf.fullAddr == RPC_CUSTOMER_OFF);
  assign hitConfig = mapIf.inRange && (mapIf.fullAddr == RPC_CONFIG_OFF);
  assign hitLocal = hitPageCtl || hitVariant || hitCustomer || hitConfig;
  assign idVariant = {MASK_REV_VAL, VARIANT_REV_VAL};

  // ==========================================================================
  // byte events within an access
  logic active;
  logic wrByte;
  logic rdByte;
  logic addrByte;
  logic twRepeat;
  assign active = (state_reg != RPC_IDLE);
  assign wrByte = (state_reg == RPC_DATA) && accByteValid && accWrite && !accStart;
  assign rdByte = (state_reg == RPC_DATA) && accByteValid && !accWrite && !accStart;
  assign addrByte = (state_reg == RPC_ADDR) && accByteValid && !accStart;
  // repeated write only for 2-wire; 4-wire always streams   R03
  assign twRepeat = pageCtl_reg[RPC_WMODE_BIT] && !spi_reg; // R02 R03

  // ==========================================================================
  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RPC_IDLE: begin
        if (accStart) begin
          state_next = RPC_DATA;
        end
      end
      RPC_DATA: begin
        if (accStart) begin
          state_next = RPC_DATA;
        end else if (accEnd) begin
          state_next = RPC_IDLE;
        end else if (wrByte && twRepeat) begin
          state_next = RPC_ADDR; // R02
        end
      end
      RPC_ADDR: begin
        if (accStart) begin
          state_next = RPC_DATA;
        end else if (accEnd) begin
          state_next = RPC_IDLE;
        end else if (addrByte) begin
          state_next = RPC_DATA;
        end
      end
      default: begin
        state_next = RPC_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // current short address: loaded at start and by address bytes, stepped per data byte except in repeated write
  always_comb begin
    curAddr_next = curAddr_reg;
    spi_next = spi_reg;
    if (accStart) begin
      curAddr_next = accAddr;
      spi_next = accIsSpi;
    end else if (addrByte) begin
      curAddr_next = accByte; // R02
    end else if (rdByte || (wrByte && !twRepeat)) begin
      curAddr_next = curAddr_reg + 8'h01; // R02 R03
    end
  end

  // ==========================================================================
  // page control register
  logic [7:0] pageWritten;
  assign pageWritten = (wrByte && hitPageCtl) ? (accByte & RPC_PAGE_CTL_MASK) : pageCtl_reg;
  always_comb begin
    pageCtl_next = pageWritten; // R06
    // with auto return set, end of access clears the page field; a write in the same cycle still counts
    if (accEnd && active && pageWritten[RPC_AUTO_RET_BIT]) begin
      pageCtl_next = {pageWritten[7:3], RPC_PAGE_ZERO}; // R01
    end
  end

  // ==========================================================================
  // read data, presented one cycle after the address settles
  always_comb begin
    rdData_next = 8'h00;
    if (hitPageCtl) begin
      rdData_next = pageCtl_reg;
    end else if (hitVariant) begin
      rdData_next = idVariant;
    end else if (hitCustomer) begin
      rdData_next = CUSTOMER_VAL;
    end else if (hitConfig) begin
      rdData_next = CONFIGURATION_REVISION_FIELD_VAL;
    end else if (mapIf.inRange) begin
      rdData_next = extRdData;
    end
  end

  // ==========================================================================
  // sequencer and page registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= RPC_IDLE;
      pageCtl_reg <= RPC_PAGE_CTL_RST;
      curAddr_reg <= 8'h00;
      spi_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pageCtl_reg <= pageCtl_next; // R01 R06
      curAddr_reg <= curAddr_next;
      spi_reg <= spi_next;
    end
  end

  // ==========================================================================
  // outward strobes toward the external register file
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      regWrite_reg <= 1'b0;
      regRead_reg <= 1'b0;
      regAddr_reg <= 10'h000;
      regWdata_reg <= 8'h00;
      rdData_reg <= 8'h00;
    end else begin
      // local and unmapped addresses never reach the outside
      regWrite_reg <= wrByte && mapIf.inRange && !hitLocal;
      regRead_reg <= rdByte && mapIf.inRange && !hitLocal;
      regAddr_reg <= mapIf.fullAddr;
      regWdata_reg <= accByte;
      rdData_reg <= rdData_next;
    end
  end

  // ==========================================================================
  // outputs
  assign regWrite = regWrite_reg;
  assign regRead = regRead_reg;
  assign regAddr = regAddr_reg;
  assign regWdata = regWdata_reg;
  assign rdData = rdData_reg;
  assign addrValid = active && mapIf.inRange;
  assign pageSel = pageCtl_reg[RPC_PAGE_MSB:0];
  assign autoReturnPage = pageCtl_reg[RPC_AUTO_RET_BIT];
  assign repeatedWrite = pageCtl_reg[RPC_WMODE_BIT];

endmodule

// ===== tb/rpc_ext_model.sv
/*
  Model of the external registers behind the page control core.
  Assumes regWrite, regAddr and regWdata come from the core on ref_clk.
*/
`timescale 1ns/10ps
module rpc_ext_model (
  input wire logic ref_clk,
  input wire logic regWrite,
  input wire logic [9:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] extRdData
);
  // ==========
  // storage
  logic [7:0] mem [1024];

  // keep written bytes; unwritten places stay unknown, never a kind zero
  always_ff @(posedge ref_clk) begin
    if (regWrite) begin
      mem[regAddr] <= regWdata;
    end
  end

  // read follows the full address the core presents
  assign extRdData = mem[regAddr];
endmodule

// ===== tb/rpc_page_control_properties.sv
/*
  Assertions on the ports of the page control core.
  Assumes a single clock and an active low asynchronous reset.
*/
`timescale 1ns/10ps
module rpc_page_control_props (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic accIsSpi,
  input wire logic accEnd,
  input wire logic accByteValid,
  input wire logic regWrite,
  input wire logic [9:0] regAddr,
  input wire logic [2:0] pageSel,
  input wire logic autoReturnPage,
  input wire logic repeatedWrite
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // ==========
  // page field life
  property p_auto_ret; autoReturnPage && accEnd && !accByteValid |=> pageSel == 3'h0; endproperty
  a_auto_ret: assert property (p_auto_ret) else $error("page kept after access end");
  property p_hold; !autoReturnPage && !accByteValid |=> $stable(pageSel); endproperty
  a_hold: assert property (p_hold) else $error("page moved without a write");

  // ==========
  // multiple writes: repeated mode needs an address byte between data
  property p_rep_gap; regWrite && repeatedWrite && !accIsSpi |=> !regWrite; endproperty
  a_rep_gap: assert property (p_rep_gap) else $error("write without address byte");
  property p_page_inc; regWrite && !repeatedWrite ##1 regWrite |-> regAddr == $past(regAddr) + 10'h1; endproperty
  a_page_inc: assert property (p_page_inc) else $error("page write address not stepped");
  property p_spi_inc; regWrite && accIsSpi ##1 regWrite |-> regAddr == $past(regAddr) + 10'h1; endproperty
  a_spi_inc: assert property (p_spi_inc) else $error("4-wire write address not stepped");

  // ==========
  // page windows
  property p_tw_map; regWrite && !accIsSpi |-> regAddr[9:8] == pageSel[2:1] && (pageSel[2:1] == 2'h0 || !regAddr[7]);
  endproperty
  a_tw_map: assert property (p_tw_map) else $error("2-wire write outside window");
  property p_spi_map; regWrite && accIsSpi |-> regAddr[9:7] == pageSel && pageSel != 3'h3 && pageSel < 3'h5; endproperty
  a_spi_map: assert property (p_spi_map) else $error("4-wire write outside window");
endmodule

bind rpc_page_control rpc_page_control_props u_props (.ref_clk(ref_clk), .rstn(rstn), .accIsSpi(accIsSpi),
  .accEnd(accEnd), .accByteValid(accByteValid), .regWrite(regWrite), .regAddr(regAddr), .pageSel(pageSel),
  .autoReturnPage(autoReturnPage), .repeatedWrite(repeatedWrite));

// ===== tb/testbench.sv
/*
  Self-checking bench for the page control core.
  Assumes the core and the external register model; strobes driven 1 ns after edges.
*/
`timescale 1ns/10ps
module testbench;
  logic ref_clk, rstn, accStart, accIsSpi, accWrite, accByteValid, accEnd;
  logic regWrite, regRead, addrValid, autoReturnPage, repeatedWrite;
  logic [7:0] accAddr, accByte, extRdData, regWdata, rdData;
  logic [9:0] regAddr;
  logic [2:0] pageSel;
  int fails = 0;
  int checksDone = 0;

  // ==========
  // instances
  rpc_page_control dut (.ref_clk(ref_clk), .rstn(rstn), .accStart(accStart), .accAddr(accAddr),
    .accIsSpi(accIsSpi), .accWrite(accWrite), .accByteValid(accByteValid), .accByte(accByte),
    .accEnd(accEnd), .extRdData(extRdData), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .rdData(rdData), .addrValid(addrValid), .pageSel(pageSel),
    .autoReturnPage(autoReturnPage), .repeatedWrite(repeatedWrite));
  rpc_ext_model ext (.ref_clk(ref_clk), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
    .extRdData(extRdData));

  // ==========
  // access tasks
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    checksDone++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: want %h got %h", $time, e, g);
    end
  endtask
  task automatic start(input logic s, input logic [7:0] a);
    accStart = 1'b1;
    accIsSpi = s;
    accAddr = a;
    accWrite = 1'b1;
    @(posedge ref_clk) #1;
    accStart = 1'b0;
  endtask
  // outputs of this byte are visible on return
  task automatic put(input logic [7:0] b);
    accByte = b;
    accByteValid = 1'b1;
    @(posedge ref_clk) #1;
  endtask
  task automatic stop;
    accByteValid = 1'b0;
    accEnd = 1'b1;
    @(posedge ref_clk) #1;
    accEnd = 1'b0;
  endtask
  task automatic setpg(input logic [7:0] v);
    start(1'b0, 8'h00);
    put(v);
    chk(16'h0, regWrite);
    stop;
  endtask

  // ==========
  // scenarios
  task automatic t_page_hold;
    setpg(8'h04);
    start(1'b0, 8'h10);
    put(8'h11);
    stop;
    chk(16'h4, pageSel);
    start(1'b0, 8'h00);
    put(8'h85);
    chk(16'h5, pageSel);
    stop;
    chk(16'h0, pageSel);
    chk(16'h1, autoReturnPage);
    setpg(8'h00);
  endtask
  task automatic t_tw_map;
    for (int p = 0; p < 8; p++) begin
      setpg(8'(p));
      start(1'b0, 8'h10);
      put(8'hA5);
      chk(16'(p < 6), regWrite);
      chk(16'(p < 6), addrValid);
      if (p < 6) chk({6'h0, p[2:1], 8'h10}, regAddr);
      stop;
    end
  endtask
  task automatic t_spi_map;
    for (int p = 0; p < 8; p++) begin
      setpg(8'(p));
      start(1'b1, 8'h10);
      put(8'h5A);
      chk(16'(p < 3 || p == 4), regWrite);
      chk(16'(p < 3 || p == 4), addrValid);
      if (p < 3 || p == 4) chk({6'h0, p[2:0], 7'h10}, regAddr);
      stop;
    end
  endtask
  // data bytes 01 then 02 under repeated write on both interfaces and under page write on 2-wire only
  task automatic t_wmode;
    setpg(8'h40);
    chk(16'h1, repeatedWrite);
    start(1'b0, 8'h20);
    put(8'h01);
    chk(16'h020, regAddr);
    put(8'h30);
    chk(16'h0, regWrite);
    put(8'h02);
    chk(16'h030, regAddr);
    chk(16'h02, regWdata);
    stop;
    start(1'b1, 8'h20);
    put(8'h01);
    put(8'h02);
    chk(16'h021, regAddr);
    stop;
    setpg(8'h00);
    start(1'b0, 8'h20);
    put(8'h01);
    put(8'h02);
    chk(16'h021, regAddr);
    stop;
  endtask
  // identity bytes in the 10x window, read only
  task automatic t_ident;
    setpg(8'h04);
    start(1'b0, 8'h02);
    accWrite = 1'b0;
    repeat (3) @(posedge ref_clk) #1;
    chk(16'h12, rdData);
    put(8'h00);
    accByteValid = 1'b0;
    repeat (3) @(posedge ref_clk) #1;
    chk(16'h5A, rdData);
    accWrite = 1'b1;
    put(8'hFF);
    chk(16'h0, regWrite);
    stop;
  endtask
  // external bytes written then read back; read strobe and window flag watched
  task automatic t_ext_rd;
    setpg(8'h00);
    start(1'b0, 8'h40);
    put(8'h3C);
    put(8'hC3);
    stop;
    chk(16'h0, addrValid);
    start(1'b0, 8'h40);
    accWrite = 1'b0;
    repeat (3) @(posedge ref_clk) #1;
    chk(16'h1, addrValid);
    chk(16'h3C, rdData);
    put(8'h00);
    accByteValid = 1'b0;
    chk(16'h1, regRead);
    chk(16'h040, regAddr);
    repeat (3) @(posedge ref_clk) #1;
    chk(16'h0, regRead);
    chk(16'hC3, rdData);
    accWrite = 1'b1;
    stop;
  endtask
  // reset in mid run drops every page field back to zero, then pages work again
  task automatic t_reset;
    setpg(8'h42);
    chk(16'h0A, {autoReturnPage, repeatedWrite, pageSel});
    rstn = 1'b0;
    @(posedge ref_clk) #1;
    chk(16'h0, {autoReturnPage, repeatedWrite, pageSel});
    rstn = 1'b1;
    @(posedge ref_clk) #1;
    chk(16'h0, {autoReturnPage, repeatedWrite, pageSel, regWrite});
    setpg(8'h01);
    chk(16'h1, pageSel);
  endtask

  // ==========
  // verdict
  task automatic report_and_stop;
    if (fails == 0 && checksDone > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // free running 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // run is under two hundred cycles; cut off well past that
  initial begin
    #40000;
    fails++;
    report_and_stop;
  end

  // main sequence
  initial begin
    rstn = 1'b0;
    {accStart, accIsSpi, accWrite, accByteValid, accEnd} = 5'h0;
    accAddr = 8'h00;
    accByte = 8'h00;
    repeat (3) @(posedge ref_clk);
    #1 rstn = 1'b1;
    chk(16'h0, {autoReturnPage, repeatedWrite, pageSel});
    t_page_hold;
    t_tw_map;
    t_spi_map;
    t_wmode;
    t_ident;
    t_ext_rd;
    t_reset;
    report_and_stop;
  end
endmodule
